/* logic/asp_consts.vh */
// Constants for the AFE serial port and path control block
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH

`define ASP_WORD_BITS 24
`define ASP_FRAME_BITS 48
`define ASP_CNT_W 6
`define ASP_FRAME_CNT 6'h30

`define ASP_CLK_MHZ 10
`define ASP_STANDBY_US 1000
`define ASP_STANDBY_CYCLES (`ASP_STANDBY_US * `ASP_CLK_MHZ)
`define ASP_IDLE_W 16

`define ASP_ADDR_W 8
`define ASP_REG_CTRL 8'h00
`define ASP_REG_PEND 8'h04
`define ASP_REG_TXSAMP 8'h08
`define ASP_REG_RXSAMP 8'h0c
`define ASP_REG_RXAUX 8'h10
`define ASP_REG_STATUS 8'h14

`define ASP_CTRL_RESET 24'h000000
`define ASP_CW_ADC_LO 0
`define ASP_CW_ADC_HI 1
`define ASP_CW_MON_LO 2
`define ASP_CW_MON_HI 3
`define ASP_CW_HANDSET 4
`define ASP_CW_WIDEBAND 5

`define ASP_ST_STANDBY 0
`define ASP_ST_AWAKE 1
`define ASP_ST_IN_BUSY 2
`define ASP_ST_OUT_BUSY 3

`endif

/* logic/asp_shift_in.v */
// Serial input shift register with bit counter
`timescale 1ns/1ps
`include "asp_consts.vh"
module asp_shift_in (
  input wire mclk,
  input wire rst,
  input wire clear,
  input wire sample,
  input wire bitIn,
  output reg [`ASP_FRAME_BITS-1:0] data,
  output reg [`ASP_CNT_W-1:0] count
);
  always @(posedge mclk)
  begin
    if (rst || clear)
    begin
      data <= {`ASP_FRAME_BITS{1'b0}};
      count <= {`ASP_CNT_W{1'b0}};
    end
    else if (sample && count != `ASP_FRAME_CNT)
    begin
      // Extra bits beyond one frame are dropped, not shifted in
      data <= {data[`ASP_FRAME_BITS-2:0], bitIn};
      count <= count + 6'h01;
    end
  end
endmodule // asp_shift_in

/* logic/asp_shift_out.v */
// Serial output shift register, most significant bit first
`timescale 1ns/1ps
`include "asp_consts.vh"
module asp_shift_out (
  input wire mclk,
  input wire rst,
  input wire load,
  input wire [`ASP_FRAME_BITS-1:0] loadData,
  input wire shift,
  output wire bitOut,
  output reg [`ASP_CNT_W-1:0] remaining
);
  reg [`ASP_FRAME_BITS-1:0] dataQ;

  assign bitOut = dataQ[`ASP_FRAME_BITS-1];

  always @(posedge mclk)
  begin
    if (rst)
    begin
      dataQ <= {`ASP_FRAME_BITS{1'b0}};
      remaining <= {`ASP_CNT_W{1'b0}};
    end
    else if (load)
    begin
      dataQ <= loadData;
      remaining <= `ASP_FRAME_CNT;
    end
    else if (shift && remaining != 6'h00)
    begin
      dataQ <= {dataQ[`ASP_FRAME_BITS-2:0], 1'b0};
      remaining <= remaining - 6'h01;
    end
  end
endmodule // asp_shift_out

/* logic/asp_top.v */
// AFE serial data/control port with path routing and APB register access
// Summary of operation
// - A falling in-frame request arms reception of two 24-bit words.
// - Serial input is sampled on each converter clock rising edge.
// - A falling out-frame request starts sending two 24-bit words.
// - Serial output changes on converter clock falling edges.
// - Output words go MSB first; samples are two's complement.
// - Out-frame window rises at data start and falls at data end.
// - Reset clears internal logic and the whole control register.
// - Line driver shutdown pin high powers down the line transmit driver.
// - Loudspeaker shutdown pin high powers down the speaker driver.
// - Wideband select bit set widens filter bandwidths.
// - Sidetone feeds speaker path when earphone, mic and transmitter are on.
// - Both ADC source bits set select the microphone input.
// - Handset select bit set enables the earphone driver.
// - Handset with both monitor bits set gives sidetone plus receive.
// - Pulse speaker output is a one-bit copy of the speaker stage.
// - Control bits wait one strobe; window fall loads the previous ones.
// - After reset release, stay idle until first converter clock rise.
// - Converter clock static 1 ms enters standby; toggling wakes it.
`timescale 1ns/1ps
`include "asp_consts.vh"
module asp_top #(
  parameter STANDBY_CYCLES = `ASP_STANDBY_CYCLES
) (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ASP_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire converterClock,
  input wire inFrameRequest,
  input wire serialInLine,
  input wire inFrameWindow,
  input wire outFrameRequest,
  output reg serialOutLine,
  output reg outFrameWindow,
  input wire lineDriverShutdown,
  input wire loudspeakerShutdown,
  input wire factoryPinA,
  input wire factoryPinB,
  output reg pulseSpeakerOut,
  output reg lineDriverOn,
  output reg speakerOn,
  output reg earphoneOn,
  output reg digitalSpeakerOn,
  output reg micSelected,
  output reg sidetoneToSpeaker,
  output reg sidetoneToEarphone,
  output reg widebandFilters,
  output reg standby
);
  reg convQ;
  reg convPrevQ;
  reg inReqQ;
  reg inReqPrevQ;
  reg inWinQ;
  reg inWinPrevQ;
  reg outReqQ;
  reg outReqPrevQ;
  reg awakeQ;
  reg [`ASP_IDLE_W-1:0] idleCntQ;
  reg inArmedQ;
  reg outBusyQ;
  reg [`ASP_WORD_BITS-1:0] ctrlQ;
  reg [`ASP_WORD_BITS-1:0] pendQ;
  reg [`ASP_WORD_BITS-1:0] txSampQ;
  reg [`ASP_WORD_BITS-1:0] rxSampQ;
  reg [`ASP_WORD_BITS-1:0] rxAuxQ;
  reg [31:0] rdataD;
  reg rdErrD;
  reg [`ASP_WORD_BITS-1:0] spkStageD;

  wire convRise = convQ & ~convPrevQ;
  wire convFall = ~convQ & convPrevQ;
  wire portsLive = awakeQ & ~standby;
  wire inReqFall = ~inReqQ & inReqPrevQ;
  wire outReqFall = ~outReqQ & outReqPrevQ;
  wire inWinFall = ~inWinQ & inWinPrevQ;
  wire factoryOk = ~factoryPinA & ~factoryPinB;
  wire apbAccess = psel & penable;
  wire apbDone = apbAccess & pready;

  wire [`ASP_FRAME_BITS-1:0] inData;
  wire [`ASP_CNT_W-1:0] inCount;
  wire outBit;
  wire [`ASP_CNT_W-1:0] outRemain;

  wire handset = ctrlQ[`ASP_CW_HANDSET];
  wire monHi = ctrlQ[`ASP_CW_MON_HI];
  wire monLo = ctrlQ[`ASP_CW_MON_LO];
  wire micSel = ctrlQ[`ASP_CW_ADC_HI] & ctrlQ[`ASP_CW_ADC_LO];

  // Pins are sampled once; the port is taken as synchronous to mclk
  always @(posedge mclk)
  begin
    if (rst)
    begin
      convQ <= 1'b0;
      convPrevQ <= 1'b0;
      inReqQ <= 1'b1;
      inReqPrevQ <= 1'b1;
      inWinQ <= 1'b0;
      inWinPrevQ <= 1'b0;
      outReqQ <= 1'b1;
      outReqPrevQ <= 1'b1;
    end
    else
    begin
      convQ <= converterClock;
      convPrevQ <= convQ;
      inReqQ <= inFrameRequest;
      inReqPrevQ <= inReqQ;
      inWinQ <= inFrameWindow;
      inWinPrevQ <= inWinQ;
      outReqQ <= outFrameRequest;
      outReqPrevQ <= outReqQ;
    end
  end

  // Awake flag and idle-clock watchdog
  always @(posedge mclk)
  begin
    if (rst)
    begin
      awakeQ <= 1'b0;
      idleCntQ <= {`ASP_IDLE_W{1'b0}};
      standby <= 1'b0;
    end
    else
    begin
      if (convRise)
        awakeQ <= 1'b1;
      if (convRise || convFall)
      begin
        idleCntQ <= {`ASP_IDLE_W{1'b0}};
        standby <= 1'b0;
      end
      else if (idleCntQ == STANDBY_CYCLES[`ASP_IDLE_W-1:0] - 16'h0001)
        standby <= 1'b1;
      else
        idleCntQ <= idleCntQ + 16'h0001;
    end
  end

  // Input frame: armed by request fall, bits taken while the window is high
  asp_shift_in uIn (
    .mclk(mclk),
    .rst(rst),
    .clear(inReqFall),
    .sample(inArmedQ & inWinQ & convRise & portsLive),
    .bitIn(serialInLine),
    .data(inData),
    .count(inCount)
  );

  always @(posedge mclk)
  begin
    if (rst)
    begin
      inArmedQ <= 1'b0;
      ctrlQ <= `ASP_CTRL_RESET;
      pendQ <= `ASP_CTRL_RESET;
      txSampQ <= {`ASP_WORD_BITS{1'b0}};
    end
    else if (!portsLive)
      inArmedQ <= 1'b0;
    else if (inReqFall)
      inArmedQ <= 1'b1;
    else if (inArmedQ && inWinFall)
    begin
      inArmedQ <= 1'b0;
      ctrlQ <= pendQ;
      // A short frame still applies the held bits but keeps nothing new
      if (inCount == `ASP_FRAME_CNT)
      begin
        txSampQ <= inData[`ASP_FRAME_BITS-1:`ASP_WORD_BITS];
        pendQ <= inData[`ASP_WORD_BITS-1:0];
      end
    end
  end

  // Output frame
  asp_shift_out uOut (
    .mclk(mclk),
    .rst(rst),
    .load(outReqFall & portsLive & ~outBusyQ),
    .loadData({rxSampQ, rxAuxQ}),
    .shift(outBusyQ & convFall),
    .bitOut(outBit),
    .remaining(outRemain)
  );

  always @(posedge mclk)
  begin
    if (rst)
    begin
      outBusyQ <= 1'b0;
      serialOutLine <= 1'b0;
      outFrameWindow <= 1'b0;
    end
    else if (!portsLive)
    begin
      outBusyQ <= 1'b0;
      serialOutLine <= 1'b0;
      outFrameWindow <= 1'b0;
    end
    else if (outReqFall && !outBusyQ)
      outBusyQ <= 1'b1;
    else if (outBusyQ && convFall)
    begin
      if (outRemain != 6'h00)
      begin
        serialOutLine <= outBit;
        outFrameWindow <= 1'b1;
      end
      else
      begin
        serialOutLine <= 1'b0;
        outFrameWindow <= 1'b0;
        outBusyQ <= 1'b0;
      end
    end
  end

  // Speaker first stage: transmit, receive or their sum by monitor code
  always @*
  begin
    spkStageD = {`ASP_WORD_BITS{1'b0}};
    if (monHi && monLo)
      spkStageD = txSampQ + rxSampQ;
    else if (monHi)
      spkStageD = rxSampQ;
    else if (monLo)
      spkStageD = txSampQ;
  end

  // Path routing outputs
  always @(posedge mclk)
  begin
    if (rst)
    begin
      pulseSpeakerOut <= 1'b0;
      lineDriverOn <= 1'b0;
      speakerOn <= 1'b0;
      earphoneOn <= 1'b0;
      digitalSpeakerOn <= 1'b0;
      micSelected <= 1'b0;
      sidetoneToSpeaker <= 1'b0;
      sidetoneToEarphone <= 1'b0;
      widebandFilters <= 1'b0;
    end
    else
    begin
      // Factory pins out of spec turn off line, speaker, earphone, digital and pulse speaker outputs
      lineDriverOn <= factoryOk & ~lineDriverShutdown;
      speakerOn <= factoryOk & ~loudspeakerShutdown & ~handset;
      earphoneOn <= factoryOk & handset & ~loudspeakerShutdown;
      digitalSpeakerOn <= factoryOk & ~handset;
      micSelected <= micSel;
      sidetoneToSpeaker <= handset & micSel & ~lineDriverShutdown;
      sidetoneToEarphone <= handset & monHi & monLo;
      widebandFilters <= ctrlQ[`ASP_CW_WIDEBAND];
      // Sign bit quantises the two's complement stage output
      pulseSpeakerOut <= factoryOk & ~handset & ~spkStageD[`ASP_WORD_BITS-1];
    end
  end

  // APB read mux
  always @*
  begin
    rdataD = 32'h00000000;
    rdErrD = 1'b0;
    if (paddr == `ASP_REG_CTRL)
      rdataD = {8'h00, ctrlQ};
    else if (paddr == `ASP_REG_PEND)
      rdataD = {8'h00, pendQ};
    else if (paddr == `ASP_REG_TXSAMP)
      rdataD = {8'h00, txSampQ};
    else if (paddr == `ASP_REG_RXSAMP)
      rdataD = {8'h00, rxSampQ};
    else if (paddr == `ASP_REG_RXAUX)
      rdataD = {8'h00, rxAuxQ};
    else if (paddr == `ASP_REG_STATUS)
    begin
      rdataD[`ASP_ST_STANDBY] = standby;
      rdataD[`ASP_ST_AWAKE] = awakeQ;
      rdataD[`ASP_ST_IN_BUSY] = inArmedQ;
      rdataD[`ASP_ST_OUT_BUSY] = outBusyQ;
    end
    else
      rdErrD = 1'b1;
  end

  // One wait state keeps pready and prdata registered
  always @(posedge mclk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      rxSampQ <= {`ASP_WORD_BITS{1'b0}};
      rxAuxQ <= {`ASP_WORD_BITS{1'b0}};
    end
    else
    begin
      pready <= apbAccess & ~pready;
      if (apbAccess && !pready)
      begin
        pslverr <= rdErrD;
        prdata <= pwrite ? 32'h00000000 : rdataD;
      end
      else
      begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
      if (apbDone && pwrite)
      begin
        if (paddr == `ASP_REG_RXSAMP)
          rxSampQ <= pwdata[`ASP_WORD_BITS-1:0];
        else if (paddr == `ASP_REG_RXAUX)
          rxAuxQ <= pwdata[`ASP_WORD_BITS-1:0];
      end
    end
  end
endmodule // asp_top

/* tb/afe_serial_port_and_path_control_tb.sv */
// Bench for the AFE serial port and path control block
`timescale 1ns/1ps
`include "asp_consts.vh"
`define CHK(got, exp) \
  begin \
    nTests++; \
    if ((got) !== (exp)) \
    begin \
      failCount++; \
      $display("mismatch %0t got %h exp %h", $time, got, exp); \
    end \
  end
module afe_serial_port_and_path_control_tb;
  localparam int STBY = 40;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic run = 1'b1;
  logic lineDriverShutdown = 1'b0;
  logic loudspeakerShutdown = 1'b0;
  logic factoryPinA = 1'b0;
  logic factoryPinB = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, converterClock, inFrameRequest, serialInLine, inFrameWindow;
  wire outFrameRequest, serialOutLine, outFrameWindow, pulseSpeakerOut, lineDriverOn;
  wire speakerOn, earphoneOn, digitalSpeakerOn, micSelected, sidetoneToSpeaker;
  wire sidetoneToEarphone, widebandFilters, standby;
  int failCount = 0;
  int nTests = 0;
  logic [47:0] rx;
  logic [31:0] q;
  logic e;
  // Pins {line off, speaker off, factory A, factory B}, then {line, speaker, pulse}
  logic [6:0] rows [7] = '{7'h07, 7'h43, 7'h25, 7'h61, 7'h10, 7'h08, 7'h07};
  asp_top #(.STANDBY_CYCLES(STBY)) u_dut (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .converterClock, .inFrameRequest, .serialInLine, .inFrameWindow, .outFrameRequest,
    .serialOutLine, .outFrameWindow, .lineDriverShutdown, .loudspeakerShutdown,
    .factoryPinA, .factoryPinB, .pulseSpeakerOut, .lineDriverOn, .speakerOn, .earphoneOn,
    .digitalSpeakerOn, .micSelected, .sidetoneToSpeaker, .sidetoneToEarphone,
    .widebandFilters, .standby
  );
  asp_dsp_model u_dsp (
    .mclk, .run, .converterClock, .inFrameRequest, .serialInLine, .inFrameWindow,
    .outFrameRequest, .serialOutLine, .outFrameWindow
  );
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Waits for pready however long it takes; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (!pready);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h00000000);
    `CHK({e, q}, {xe, x})
  endtask
  // Control loads a few cycles after the window closes
  task automatic frame(input logic [47:0] tx);
    u_dsp.xfer(tx, rx);
    repeat (8) @(posedge mclk);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(`ASP_REG_CTRL, 32'h00000000, 1'b0);
    rd(8'h18, 32'h00000000, 1'b1);
    apb(1'b1, `ASP_REG_CTRL, 32'h0000003f);
    rd(`ASP_REG_CTRL, 32'h00000000, 1'b0);
    foreach (rows[i])
    begin
      {lineDriverShutdown, loudspeakerShutdown, factoryPinA, factoryPinB} <= rows[i][6:3];
      repeat (3) @(posedge mclk);
      `CHK({lineDriverOn, speakerOn, pulseSpeakerOut}, rows[i][2:0])
    end
    apb(1'b1, `ASP_REG_RXSAMP, 32'h00a5c30f);
    apb(1'b1, `ASP_REG_RXAUX, 32'h003c5a96);
    frame({24'h812345, 24'h00003f});
    `CHK(rx, 48'ha5c30f3c5a96)
    rd(`ASP_REG_TXSAMP, 32'h00812345, 1'b0);
    rd(`ASP_REG_PEND, 32'h0000003f, 1'b0);
    `CHK({micSelected, widebandFilters}, 2'b00)
    frame({24'h7ffffe, 24'h000013});
    `CHK({micSelected, widebandFilters, earphoneOn, digitalSpeakerOn}, 4'he)
    `CHK({sidetoneToEarphone, sidetoneToSpeaker, speakerOn}, 3'h6)
    rd(`ASP_REG_TXSAMP, 32'h007ffffe, 1'b0);
    frame({24'h000000, 24'h00000c});
    rd(`ASP_REG_CTRL, 32'h00000013, 1'b0);
    lineDriverShutdown <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK({micSelected, widebandFilters, sidetoneToEarphone, sidetoneToSpeaker}, 4'h8)
    // Monitor code 11 without handset: zero sample plus negative receive word gives low pulse
    frame({24'h000000, 24'h000000});
    `CHK({pulseSpeakerOut, digitalSpeakerOn, speakerOn}, 3'h3)
    run <= 1'b0;
    repeat (STBY + 20) @(posedge mclk);
    `CHK(standby, 1'b1)
    run <= 1'b1;
    repeat (20) @(posedge mclk);
    `CHK(standby, 1'b0)
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(`ASP_REG_PEND, 32'h00000000, 1'b0);
    `CHK({micSelected, earphoneOn}, 2'b00)
    printVerdict();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    failCount++;
    printVerdict();
  end
endmodule // afe_serial_port_and_path_control_tb

/* tb/asp_dsp_model.sv */
// Behavioural DSP driving the serial frame pins
`timescale 1ns/1ps
module asp_dsp_model (
  input wire mclk,
  input wire run,
  output logic converterClock,
  output logic inFrameRequest,
  output logic serialInLine,
  output logic inFrameWindow,
  output logic outFrameRequest,
  input wire serialOutLine,
  input wire outFrameWindow
);
  logic [2:0] div_q;
  logic fell_q;
  logic rose_q;
  initial
  begin
    {converterClock, div_q, fell_q, rose_q, serialInLine, inFrameWindow} = '0;
    {inFrameRequest, outFrameRequest} = 2'b11;
  end
  // Runs without pause; halted only to force standby
  always @(posedge mclk)
  begin
    fell_q <= run && div_q == 3'h4 && converterClock;
    rose_q <= run && div_q == 3'h4 && !converterClock;
    if (run)
    begin
      div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
      converterClock <= converterClock ^ (div_q == 3'h4);
    end
  end
  task automatic waitEdge(input logic fall);
    @(posedge mclk);
    while (fall ? !fell_q : !rose_q)
      @(posedge mclk);
  endtask
  // Sample word then control word, MSB first, in one window
  task automatic xfer(input logic [47:0] tx, output logic [47:0] rx);
    rx = '0;
    waitEdge(1'b1);
    inFrameRequest <= 1'b0;
    outFrameRequest <= 1'b0;
    fork
      begin
        waitEdge(1'b1);
        inFrameWindow <= 1'b1;
        for (int i = 47; i >= 0; i--)
        begin
          serialInLine <= tx[i];
          waitEdge(1'b1);
        end
        inFrameWindow <= 1'b0;
        // Released line shows the inverse, never a stale bit
        serialInLine <= ~tx[0];
      end
      for (int k = 0; k < 48;)
      begin
        waitEdge(1'b0);
        if (outFrameWindow)
        begin
          rx = {rx[46:0], serialOutLine};
          k++;
        end
      end
    join
    inFrameRequest <= 1'b1;
    outFrameRequest <= 1'b1;
  endtask
endmodule // asp_dsp_model

/* tb/asp_monitor.sv */
// Port checker for the AFE serial port block
`timescale 1ns/1ps
module asp_monitor (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire converterClock,
  input wire inFrameWindow,
  input wire serialOutLine,
  input wire outFrameWindow,
  input wire lineDriverShutdown,
  input wire loudspeakerShutdown,
  input wire lineDriverOn,
  input wire speakerOn,
  input wire earphoneOn,
  input wire digitalSpeakerOn,
  input wire micSelected,
  input wire widebandFilters
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_reset; $fell(rst) |-> !(outFrameWindow | serialOutLine | micSelected); endproperty
  a_reset: assert property (p_reset) else $error("state kept over reset");
  property p_line; $past(lineDriverShutdown) |-> !lineDriverOn; endproperty
  a_line: assert property (p_line) else $error("line driver on");
  property p_spk; $past(loudspeakerShutdown) |-> !speakerOn && !earphoneOn; endproperty
  a_spk: assert property (p_spk) else $error("speaker on");
  property p_hand; earphoneOn |-> !digitalSpeakerOn && !speakerOn; endproperty
  a_hand: assert property (p_hand) else $error("earphone with speaker");
  // Control outputs move only once the input window has closed
  property p_ctrl; $changed({micSelected, widebandFilters}) |-> !inFrameWindow; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control moved in window");
  property p_edge; $changed(serialOutLine) |-> !converterClock; endproperty
  a_edge: assert property (p_edge) else $error("bit moved on high half");
  property p_idle; !outFrameWindow |-> !serialOutLine; endproperty
  a_idle: assert property (p_idle) else $error("data outside window");
  property p_apb; psel && penable && !pready |=> pready; endproperty
  a_apb: assert property (p_apb) else $error("no ready after one wait");
endmodule // asp_monitor

bind asp_top asp_monitor u_mon (
  .mclk, .rst, .psel, .penable, .pready, .converterClock, .inFrameWindow, .serialOutLine,
  .outFrameWindow, .lineDriverShutdown, .loudspeakerShutdown, .lineDriverOn, .speakerOn,
  .earphoneOn, .digitalSpeakerOn, .micSelected, .widebandFilters
);
